/* include/reader_consts.svh */
// Notes on behaviour
// (RL1) host serial port rate selectable among standard rates 9.6 to 921.6 kbaud.
// (RL2) host serial port runs at 115.2 kbaud after power-up until reconfigured.
// (RL3) reader commands arrive on host receive line; answers leave on transmit line.
// (RL4) diagnostic port sends microcontroller status; nothing need listen to it.
// (RL5) a diagnostic listener keeps one fixed 115.2 kbaud rate.
// (RL6) boot select low (pulled down) starts the flash bootstrap.
// (RL7) boot select high at power-up runs the ROM bootloader; host uses it for recovery.
// (RL8) module held in reset while reset line low, leaves reset when high.
// (RL9) reset line is two-way; module may pull it low; others stay high-impedance.
// (RL10) outside logic asserts reset only by open drain or switch to ground.
// (RL11) readiness output toggles at 1 Hz once boot completed and operational.
// (RL12) tag-activity output toggles at 1 Hz while tags are being inventoried.
// (RL13) tag-activity output held low when no inventory is running.
// (RL14) four user I/O lines, each configurable independently.
// (RL15) auxiliary converter codes are 12 bits across full scale.
// (RL16) host configures reader, idle mode, starts and stops operations by commands.
// (RL17) user I/O lines can trigger inventory and signal inventory events.
// (RL18) readiness output holds steady before boot completes or after boot failure.
// (RL19) both serial ports use 8 data bits, no parity, one stop bit.
`ifndef READER_CONSTS_SVH
`define READER_CONSTS_SVH
`define CLK_HZ 20000000
`define BAUD_0 9600
`define BAUD_1 19200
`define BAUD_2 38400
`define BAUD_3 57600
`define BAUD_4 115200
`define BAUD_5 230400
`define BAUD_6 460800
`define BAUD_7 921600
`define HOST_BAUD_DEF 3'h4
`define DBG_BAUD_SEL 3'h4
`define IND_PERIOD_MS 1000
`define PWRUP_HOLD_US 100
`define PWRUP_CYC (`CLK_HZ / 1000000 * `PWRUP_HOLD_US)
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_HOST_TX 8'h08
`define A_HOST_RX 8'h0c
`define A_DBG_TX 8'h10
`define A_IO_MODE 8'h14
`define A_IO_OUT 8'h18
`define A_IO_IN 8'h1c
`define A_DAC 8'h20
`define A_ADC 8'h24
`define CTRL_BOOT_OK 3
`define CTRL_BOOT_FAIL 4
`define CTRL_INV 5
`define CTRL_RST_REQ 6
`define STAT_TRIG 7
`endif

/* include/reader_pkg.sv */
package reader_pkg;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_START = 2'b01,
		SER_DATA = 2'b11,
		SER_STOP = 2'b10
	} ser_state_e;
	typedef enum logic [1:0] {
		IO_IN = 2'h0,
		IO_OUT = 2'h1,
		IO_TRIG = 2'h2,
		IO_EVENT = 2'h3
	} io_mode_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_s;
endpackage

/* src/serial_port.sv */
module serial_port
	import reader_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic [11:0] divisor,
	input wire byte_s txReq,
	output logic txBusy,
	output logic txPin,
	input wire logic rxPin,
	output byte_s rxOut
);
	ser_state_e txSt_q, rxSt_q;
	logic [11:0] txCnt_q, rxCnt_q;
	logic [2:0] txBit_q, rxBit_q;
	logic [7:0] txSh_q, rxSh_q;
	logic rxS1_q, rxS2_q;

	assign txBusy = txSt_q != SER_IDLE;

	// start, 8 data lsb first, stop
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			txSt_q <= SER_IDLE;
			txCnt_q <= 12'h000;
			txBit_q <= 3'h0;
			txSh_q <= 8'h00;
			txPin <= 1'b1;
		end else if (clear) begin
			txSt_q <= SER_IDLE;
			txPin <= 1'b1;
		end else if (txSt_q == SER_IDLE) begin
			if (txReq.valid) begin
				txSt_q <= SER_START; // RL19
				txSh_q <= txReq.data;
				txCnt_q <= divisor - 12'h001;
				txPin <= 1'b0;
			end
		end else if (txCnt_q != 12'h000) begin
			txCnt_q <= txCnt_q - 12'h001;
		end else begin
			txCnt_q <= divisor - 12'h001;
			unique case (txSt_q)
				SER_START, SER_DATA: begin
					if (txSt_q == SER_DATA && txBit_q == 3'h7) begin
						txSt_q <= SER_STOP; // RL19
						txPin <= 1'b1;
					end else begin
						if (txSt_q == SER_DATA) begin
							txBit_q <= txBit_q + 3'h1;
						end else begin
							txBit_q <= 3'h0;
						end
						txSt_q <= SER_DATA;
						txPin <= txSh_q[0];
						txSh_q <= txSh_q >> 1;
					end
				end
				SER_STOP: txSt_q <= SER_IDLE;
				SER_IDLE: txSt_q <= SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxS1_q <= 1'b1;
			rxS2_q <= 1'b1;
		end else begin
			rxS1_q <= rxPin;
			rxS2_q <= rxS1_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxSt_q <= SER_IDLE;
			rxCnt_q <= 12'h000;
			rxBit_q <= 3'h0;
			rxSh_q <= 8'h00;
			rxOut <= '0;
		end else begin
			rxOut.valid <= 1'b0;
			if (clear) begin
				rxSt_q <= SER_IDLE;
			end else if (rxSt_q == SER_IDLE) begin
				if (!rxS2_q) begin
					rxSt_q <= SER_START;
					rxCnt_q <= divisor >> 1;
				end
			end else if (rxCnt_q != 12'h000) begin
				rxCnt_q <= rxCnt_q - 12'h001;
			end else begin
				rxCnt_q <= divisor - 12'h001;
				unique case (rxSt_q)
					SER_START: begin
						rxSt_q <= rxS2_q ? SER_IDLE : SER_DATA;
						rxBit_q <= 3'h0;
					end
					SER_DATA: begin
						rxSh_q <= {rxS2_q, rxSh_q[7:1]};
						rxBit_q <= rxBit_q + 3'h1;
						if (rxBit_q == 3'h7) begin
							rxSt_q <= SER_STOP;
						end
					end
					SER_STOP: begin
						rxSt_q <= SER_IDLE; // RL19
						rxOut.valid <= rxS2_q;
						rxOut.data <= rxSh_q;
					end
					SER_IDLE: rxSt_q <= SER_IDLE;
				endcase
			end
		end
	end

	txStartLow_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL19
		txSt_q == SER_IDLE && txReq.valid && !clear |=> !txPin && txBusy)
		else $error("start bit not driven low");
	rxOnePulse_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL19
		rxOut.valid |=> !rxOut.valid && rxSt_q == SER_IDLE)
		else $error("receive pulse longer than one cycle");
endmodule

/* src/reader_host_ctrl.sv */
// Decided for this implementation: the placing of the registers and strobed register access.
`include "reader_consts.svh"

module reader_host_ctrl
	import reader_pkg::*;
#(
	parameter int HALF_CYC = `CLK_HZ / 1000 * `IND_PERIOD_MS / 2
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire reg_req_s regReq,
	output logic [31:0] regRdata,
	input wire logic hostRxPin,
	output logic hostTxPin,
	output logic dbgTxPin,
	input wire logic boot_select_in,
	output logic bootFromRom,
	input wire logic reset_line_n_in,
	output logic reset_line_n_out,
	output logic reset_line_n_oe,
	output logic coreHeld,
	input wire logic user_io_1_in,
	output logic user_io_1_out,
	output logic user_io_1_oe,
	input wire logic user_io_2_in,
	output logic user_io_2_out,
	output logic user_io_2_oe,
	input wire logic user_io_3_in,
	output logic user_io_3_out,
	output logic user_io_3_oe,
	input wire logic user_io_4_in,
	output logic user_io_4_out,
	output logic user_io_4_oe,
	output logic healthLed,
	output logic statusLed,
	output logic [11:0] dacCode,
	input wire logic [11:0] adcCode
);
	function automatic logic [11:0] baudDiv(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h0: rate = `BAUD_0;
			3'h1: rate = `BAUD_1;
			3'h2: rate = `BAUD_2;
			3'h3: rate = `BAUD_3;
			3'h4: rate = `BAUD_4;
			3'h5: rate = `BAUD_5;
			3'h6: rate = `BAUD_6;
			default: rate = `BAUD_7;
		endcase
		baudDiv = 12'((`CLK_HZ + rate / 2) / rate);
	endfunction

	logic [17:0] pinS1_q, pinS2_q;
	logic [3:0] ioIn, ioPrev_q, trigEdge, ioOut_q, ioOe_q, gpioOut_q;
	logic [7:0] gpioMode_q;
	logic lineHeld;
	logic [11:0] pwrCnt_q, hostDiv, dac_q;
	logic [2:0] baudSel_q;
	logic bootOk_q, bootFail_q, invActive_q, trigFlag_q, bootRom_q;
	logic healthOk, tick;
	logic [23:0] tickCnt_q;
	logic healthLed_q, statusLed_q;
	logic wrCtrl, wrStat, wrMode, wrOut, wrDac, rdHostRx;
	byte_s hostTxReq, dbgTxReq, hostRxOut;
	logic hostTxBusy, dbgTxBusy;
	logic [7:0] hostRxData_q;
	logic hostRxHave_q;
	logic [31:0] rdata_q;

	assign ioIn = {user_io_4_in, user_io_3_in, user_io_2_in, user_io_1_in};

	// pin synchronisers: boot, line, user io, converter code
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinS1_q <= 18'h00002;
			pinS2_q <= 18'h00002;
			ioPrev_q <= 4'h0;
		end else begin
			pinS1_q <= {adcCode, ioIn, reset_line_n_in, boot_select_in};
			pinS2_q <= pinS1_q;
			ioPrev_q <= pinS2_q[5:2];
		end
	end

	assign lineHeld = !pinS2_q[1]; // RL8
	assign coreHeld = lineHeld;

	assign wrCtrl = regReq.wr && regReq.addr == `A_CTRL;
	assign wrStat = regReq.wr && regReq.addr == `A_STAT;
	assign wrMode = regReq.wr && regReq.addr == `A_IO_MODE;
	assign wrOut = regReq.wr && regReq.addr == `A_IO_OUT;
	assign wrDac = regReq.wr && regReq.addr == `A_DAC;
	assign rdHostRx = regReq.rd && regReq.addr == `A_HOST_RX;

	// reset line: pulled low only, at power-up and on software request
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwrCnt_q <= 12'(`PWRUP_CYC);
		end else if (wrCtrl && regReq.wdata[`CTRL_RST_REQ]) begin
			pwrCnt_q <= 12'(`PWRUP_CYC); // RL9
		end else if (pwrCnt_q != 12'h000) begin
			pwrCnt_q <= pwrCnt_q - 12'h001;
		end
	end

	assign reset_line_n_out = 1'b0;
	assign reset_line_n_oe = pwrCnt_q != 12'h000; // RL9

	// boot mode caught while the line holds the module in reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bootRom_q <= 1'b0;
		end else if (lineHeld) begin
			bootRom_q <= pinS2_q[0]; // RL6 RL7
		end
	end

	assign bootFromRom = bootRom_q;

	// control register, returns to defaults while held in reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			baudSel_q <= `HOST_BAUD_DEF;
			bootOk_q <= 1'b0;
			bootFail_q <= 1'b0;
			invActive_q <= 1'b0;
		end else if (lineHeld) begin
			baudSel_q <= `HOST_BAUD_DEF; // RL2
			bootOk_q <= 1'b0;
			bootFail_q <= 1'b0;
			invActive_q <= 1'b0;
		end else begin
			if (wrCtrl) begin
				baudSel_q <= regReq.wdata[2:0]; // RL1
				bootOk_q <= regReq.wdata[`CTRL_BOOT_OK];
				bootFail_q <= regReq.wdata[`CTRL_BOOT_FAIL];
			end
			if (|trigEdge) begin
				invActive_q <= 1'b1; // RL17
			end else if (wrCtrl) begin
				invActive_q <= regReq.wdata[`CTRL_INV];
			end
		end
	end

	assign hostDiv = baudDiv(baudSel_q); // RL1

	// trigger seen flag, an edge wins over a clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			trigFlag_q <= 1'b0;
		end else if (|trigEdge) begin
			trigFlag_q <= 1'b1; // RL17
		end else if (lineHeld || (wrStat && regReq.wdata[`STAT_TRIG])) begin
			trigFlag_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gpioMode_q <= 8'h00;
			gpioOut_q <= 4'h0;
			dac_q <= 12'h000;
		end else if (lineHeld) begin
			gpioMode_q <= 8'h00;
			gpioOut_q <= 4'h0;
		end else begin
			if (wrMode) begin
				gpioMode_q <= regReq.wdata[7:0]; // RL14
			end
			if (wrOut) begin
				gpioOut_q <= regReq.wdata[3:0];
			end
			if (wrDac) begin
				dac_q <= regReq.wdata[11:0]; // RL15
			end
		end
	end

	assign dacCode = dac_q;

	// per line: input, output, trigger input, inventory event output
	for (genvar i = 0; i < 4; i++) begin : g_io
		io_mode_e mode;
		assign mode = io_mode_e'(gpioMode_q[2*i +: 2]);
		assign trigEdge[i] = mode == IO_TRIG && pinS2_q[2+i] && !ioPrev_q[i] && !lineHeld; // RL17
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				ioOut_q[i] <= 1'b0;
				ioOe_q[i] <= 1'b0;
			end else begin
				ioOe_q[i] <= mode == IO_OUT || mode == IO_EVENT; // RL14
				ioOut_q[i] <= mode == IO_EVENT ? invActive_q : gpioOut_q[i]; // RL17
			end
		end
	end

	assign user_io_1_out = ioOut_q[0];
	assign user_io_2_out = ioOut_q[1];
	assign user_io_3_out = ioOut_q[2];
	assign user_io_4_out = ioOut_q[3];
	assign user_io_1_oe = ioOe_q[0];
	assign user_io_2_oe = ioOe_q[1];
	assign user_io_3_oe = ioOe_q[2];
	assign user_io_4_oe = ioOe_q[3];

	// half-period tick for both indicators
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_q <= 24'h000000;
		end else if (tick) begin
			tickCnt_q <= 24'h000000;
		end else begin
			tickCnt_q <= tickCnt_q + 24'h000001;
		end
	end

	assign tick = tickCnt_q >= 24'(HALF_CYC - 1);
	assign healthOk = bootOk_q && !bootFail_q && !lineHeld;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			healthLed_q <= 1'b0;
		end else if (!healthOk) begin
			healthLed_q <= 1'b0; // RL18
		end else if (tick) begin
			healthLed_q <= !healthLed_q; // RL11
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			statusLed_q <= 1'b0;
		end else if (!invActive_q || lineHeld) begin
			statusLed_q <= 1'b0; // RL13
		end else if (tick) begin
			statusLed_q <= !statusLed_q; // RL12
		end
	end

	assign healthLed = healthLed_q;
	assign statusLed = statusLed_q;

	// serial ports; a write while busy is dropped
	assign hostTxReq = {regReq.wr && regReq.addr == `A_HOST_TX, regReq.wdata[7:0]}; // RL3
	assign dbgTxReq = {regReq.wr && regReq.addr == `A_DBG_TX, regReq.wdata[7:0]}; // RL4

	serial_port u_host (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clear(lineHeld),
		.divisor(hostDiv),
		.txReq(hostTxReq),
		.txBusy(hostTxBusy),
		.txPin(hostTxPin),
		.rxPin(hostRxPin),
		.rxOut(hostRxOut)
	);

	serial_port u_dbg (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clear(lineHeld),
		.divisor(baudDiv(`DBG_BAUD_SEL)),
		.txReq(dbgTxReq),
		.txBusy(dbgTxBusy),
		.txPin(dbgTxPin),
		.rxPin(1'b1),
		.rxOut()
	);

	// received command byte, a new byte wins over the read that clears
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hostRxData_q <= 8'h00;
			hostRxHave_q <= 1'b0;
		end else if (hostRxOut.valid) begin
			hostRxData_q <= hostRxOut.data; // RL3
			hostRxHave_q <= 1'b1;
		end else if (rdHostRx || lineHeld) begin
			hostRxHave_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 32'h00000000;
		end else if (regReq.rd) begin
			case (regReq.addr)
				`A_CTRL: rdata_q <= {26'h0, invActive_q, bootFail_q, bootOk_q, baudSel_q};
				`A_STAT: rdata_q <= {24'h0, trigFlag_q, pinS2_q[1], dbgTxBusy, hostTxBusy,
					hostRxHave_q, statusLed_q, healthLed_q, bootRom_q};
				`A_HOST_RX: rdata_q <= {24'h0, hostRxData_q};
				`A_IO_MODE: rdata_q <= {24'h0, gpioMode_q};
				`A_IO_OUT: rdata_q <= {28'h0, gpioOut_q};
				`A_IO_IN: rdata_q <= {28'h0, pinS2_q[5:2]};
				`A_DAC: rdata_q <= {20'h0, dac_q};
				`A_ADC: rdata_q <= {20'h0, pinS2_q[17:6]}; // RL15
				default: rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	assign regRdata = rdata_q;

	sequence resetReqWrite;
		wrCtrl && regReq.wdata[`CTRL_RST_REQ];
	endsequence

	baudDefault_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL2
		lineHeld |=> hostDiv == baudDiv(`HOST_BAUD_DEF))
		else $error("host rate not default after reset");
	baudSelect_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL1
		wrCtrl && !lineHeld |=> hostDiv == baudDiv($past(regReq.wdata[2:0])))
		else $error("host rate not taken from write");
	healthSteady_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL18
		!healthOk |=> !healthLed_q)
		else $error("readiness output not steady before boot");
	healthToggle_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL11
		healthOk && tick |=> healthLed_q != $past(healthLed_q))
		else $error("readiness output did not toggle");
	statusLow_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL13
		!invActive_q |=> !statusLed_q)
		else $error("activity output not low when idle");
	statusToggle_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL12
		invActive_q && !lineHeld && tick |=> statusLed_q != $past(statusLed_q))
		else $error("activity output did not toggle");
	bootCapture_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL7
		lineHeld |=> bootFromRom == $past(pinS2_q[0]))
		else $error("boot mode not caught in reset");
	resetDrive_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL9
		resetReqWrite |=> reset_line_n_oe [*8])
		else $error("reset line not pulled low on request");
	trigSetWins_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL17
		|trigEdge |=> trigFlag_q && invActive_q)
		else $error("trigger edge lost");
	dacLoad_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL15
		wrDac && !lineHeld |=> dacCode == $past(regReq.wdata[11:0]))
		else $error("converter code not loaded");
	heldClear_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RL8
		lineHeld [*3] |-> !healthLed_q && !statusLed_q && ioOe_q == 4'h0)
		else $error("outputs active while held in reset");
endmodule

/* tb/host_side_model.sv */
module host_side_model (
	input wire logic core_clk,
	input wire logic hostTxPin,
	input wire logic dbgTxPin,
	input wire logic reset_line_n_oe,
	output logic hostRxPin,
	output logic boot_select_in,
	output logic resetWire
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pullLow;
	// pull-up, module pull, host switch to ground; never driven high
	assign resetWire = !(reset_line_n_oe || pullLow);
	initial begin
		hostRxPin = 1'b1;
		boot_select_in = 1'b0;
		pullLow = 1'b1;
	end
	// one command byte, start, lsb first, stop
	task automatic send(input logic [7:0] b, input int div);
		logic [9:0] frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			hostRxPin <= frame[i];
			repeat (div - 1) @(posedge core_clk);
		end
	endtask
	// stop bit lands in bit 8
	task automatic recv(input logic dbg, input int div, output logic [8:0] got);
		int n = 0;
		got = '1;
		while ((dbg ? dbgTxPin : hostTxPin) !== 1'b0 && n < 4 * div) begin
			@(posedge core_clk);
			n++;
		end
		repeat (div / 2) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (div) @(posedge core_clk);
			got[i] = dbg ? dbgTxPin : hostTxPin;
		end
		// let the stop bit finish so the next write is not dropped
		repeat (div / 2 + 2) @(posedge core_clk);
	endtask
endmodule

/* tb/reader_host_ctrl_test.sv */
`include "reader_consts.svh"
`define EXPECT(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin \
	$display("wrong value %s expected %h seen %h", n, e, s); nMismatch++; end end

module reader_host_ctrl_test
	import reader_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 20;
	localparam int RATE [8] = '{`BAUD_0, `BAUD_1, `BAUD_2, `BAUD_3,
		`BAUD_4, `BAUD_5, `BAUD_6, `BAUD_7};
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	reg_req_s regReq = '0;
	logic [31:0] regRdata, rdv;
	logic hostRxPin, hostTxPin, dbgTxPin, bootSel, bootFromRom, resetWire;
	logic resetOe, resetOut, coreHeld, healthLed, statusLed;
	logic [3:0] ioOut, ioOe, ioPin;
	logic [3:0] ioLvl = 4'h0;
	logic [11:0] dacCode;
	logic [11:0] adcCode = 12'h000;
	logic [8:0] got;
	int nMismatch = 0;
	int samplesChecked = 0;
	int n;
	assign ioPin = (ioOe & ioOut) | (~ioOe & ioLvl);
	always #25 core_clk = ~core_clk;
	reader_host_ctrl #(.HALF_CYC(HALF)) DUT (
		.core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
		.hostRxPin(hostRxPin), .hostTxPin(hostTxPin), .dbgTxPin(dbgTxPin),
		.boot_select_in(bootSel), .bootFromRom(bootFromRom),
		.reset_line_n_in(resetWire), .reset_line_n_out(resetOut), .reset_line_n_oe(resetOe),
		.coreHeld(coreHeld),
		.user_io_1_in(ioPin[0]), .user_io_1_out(ioOut[0]), .user_io_1_oe(ioOe[0]),
		.user_io_2_in(ioPin[1]), .user_io_2_out(ioOut[1]), .user_io_2_oe(ioOe[1]),
		.user_io_3_in(ioPin[2]), .user_io_3_out(ioOut[2]), .user_io_3_oe(ioOe[2]),
		.user_io_4_in(ioPin[3]), .user_io_4_out(ioOut[3]), .user_io_4_oe(ioOe[3]),
		.healthLed(healthLed), .statusLed(statusLed), .dacCode(dacCode),
		.adcCode(adcCode)
	);
	host_side_model HOST (
		.core_clk(core_clk), .hostTxPin(hostTxPin), .dbgTxPin(dbgTxPin),
		.reset_line_n_oe(resetOe), .hostRxPin(hostRxPin),
		.boot_select_in(bootSel), .resetWire(resetWire)
	);
	function automatic int dv(int i);
		return (`CLK_HZ + RATE[i] / 2) / RATE[i];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regReq <= {1'b1, 1'b0, a, d};
		@(posedge core_clk);
		regReq.wr <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		@(posedge core_clk);
		regReq <= {1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk);
		regReq.rd <= 1'b0;
		#1 rdv = regRdata;
		`EXPECT($sformatf("reg %h", a), e & m, rdv & m)
	endtask
	task automatic toggles(input logic st, output int c);
		logic prev;
		c = 0;
		@(posedge core_clk);
		#1 prev = st ? statusLed : healthLed;
		repeat (10 * HALF) begin
			@(posedge core_clk);
			#1 if ((st ? statusLed : healthLed) !== prev) c++;
			prev = st ? statusLed : healthLed;
		end
	endtask
	task automatic pulseLen(output int c);
		c = 0;
		while (resetOe === 1'b1 && c < 3000) begin
			@(posedge core_clk);
			#1 c++;
		end
	endtask
	task automatic conclude();
		$display("checked %0d mismatched %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		nMismatch++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		HOST.boot_select_in <= 1'b1;
		#1 `EXPECT("pull in reset", 1'b1, resetOe)
		`EXPECT("pull level", 1'b0, resetOut)
		@(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1 pulseLen(n);
		`EXPECT("power-up pull", 1'b1, n >= `PWRUP_CYC - 3 && n <= `PWRUP_CYC + 3)
		repeat (10) @(posedge core_clk);
		#1 `EXPECT("held by host", 1'b1, coreHeld)
		wr(`A_CTRL, 32'h8);
		rdChk(`A_CTRL, 32'h4);
		HOST.pullLow <= 1'b0;
		repeat (6) @(posedge core_clk);
		HOST.boot_select_in <= 1'b0;
		#1 `EXPECT("released", 1'b0, coreHeld)
		rdChk(`A_STAT, 32'h41);
		`EXPECT("boot from rom", 1'b1, bootFromRom)
		toggles(1'b0, n);
		`EXPECT("health unbooted", 0, n)
		wr(`A_HOST_TX, 32'ha5);
		HOST.recv(1'b0, dv(4), got);
		`EXPECT("default tx", 9'h1a5, got)
		HOST.send(8'h3c, dv(4));
		rdChk(`A_STAT, 32'h49);
		rdChk(`A_HOST_RX, 32'h3c);
		rdChk(`A_STAT, 32'h41, 32'hfd);
		for (int i = 0; i < 8; i++) begin
			wr(`A_CTRL, 32'h8 | i);
			wr(`A_HOST_TX, 32'h50 + i);
			HOST.recv(1'b0, dv(i), got);
			`EXPECT("rate tx", {1'b1, 8'h50 + i[7:0]}, got)
		end
		HOST.send(8'hc3, dv(7));
		rdChk(`A_HOST_RX, 32'hc3);
		wr(`A_DBG_TX, 32'h96);
		HOST.recv(1'b1, dv(4), got);
		`EXPECT("dbg tx", 9'h196, got)
		toggles(1'b0, n);
		`EXPECT("health booted", 10, n)
		wr(`A_CTRL, 32'h1c);
		toggles(1'b0, n);
		`EXPECT("health failed", 0, n)
		`EXPECT("health level", 1'b0, healthLed)
		wr(`A_CTRL, 32'hc);
		toggles(1'b1, n);
		`EXPECT("status idle", 0, n)
		`EXPECT("status low", 1'b0, statusLed)
		wr(`A_IO_MODE, 32'he1);
		wr(`A_IO_OUT, 32'h1);
		@(posedge core_clk);
		#1 `EXPECT("io enables", 4'h9, ioOe)
		`EXPECT("io outs", 2'b01, {ioOut[3], ioOut[0]})
		ioLvl <= 4'h6;
		repeat (5) @(posedge core_clk);
		rdChk(`A_STAT, 32'h80, 32'h80);
		rdChk(`A_CTRL, 32'h2c);
		rdChk(`A_IO_IN, 32'hf);
		rdChk(`A_IO_MODE, 32'he1);
		`EXPECT("event out", 1'b1, ioOut[3])
		toggles(1'b1, n);
		`EXPECT("status active", 10, n)
		wr(`A_CTRL, 32'hc);
		wr(`A_STAT, 32'h80);
		rdChk(`A_STAT, 32'h0, 32'h80);
		toggles(1'b1, n);
		`EXPECT("status stopped", 0, n)
		wr(`A_DAC, 32'h1fff);
		rdChk(`A_DAC, 32'hfff);
		`EXPECT("dac code", 12'hfff, dacCode)
		adcCode <= 12'ha5c;
		repeat (4) @(posedge core_clk);
		rdChk(`A_ADC, 32'ha5c);
		// unmapped place: reads zero, write lost
		wr(8'h30, 32'hffffffff);
		rdChk(8'h30, 32'h0);
		wr(`A_CTRL, 32'h4c);
		repeat (100) @(posedge core_clk);
		#1 `EXPECT("held by module", 1'b1, coreHeld)
		pulseLen(n);
		`EXPECT("pull length", 1'b1, n + 100 >= `PWRUP_CYC - 3 && n + 100 <= `PWRUP_CYC + 3)
		repeat (6) @(posedge core_clk);
		rdChk(`A_CTRL, 32'h4);
		rdChk(`A_STAT, 32'h40, 32'h41);
		`EXPECT("boot from flash", 1'b0, bootFromRom)
		wr(`A_HOST_TX, 32'h81);
		HOST.recv(1'b0, dv(4), got);
		`EXPECT("tx after reset", 9'h181, got)
		conclude();
	end
endmodule
